// File: logic/fptc_consts.svh
// constants for the functional pin test control block
`ifndef FPTC_CONSTS_SVH
`define FPTC_CONSTS_SVH

`define FPTC_NPINS 240
`define FPTC_RANK_W 30
`define FPTC_NRANK 8
`define FPTC_RANK_SEL_W 3
`define FPTC_DATA_W 30
`define FPTC_DLY_W 16
`define FPTC_SYNC_W 8
`define FPTC_NSUP 3
`define FPTC_NROUTE 4
`define FPTC_STB_BITS 4
`define FPTC_DLY_RST 16'h0001
`define FPTC_DCDLY_RST 16'h0001
`define FPTC_SYNC_RST 8'h00
`define FPTC_LIM_HI_RST 16'hFFFF
`define FPTC_LIM_LO_RST 16'h0000

`endif

// File: logic/fptc_pkg.sv
// types for the functional pin test control block
package fptc_pkg;

   typedef enum logic [4:0] {
      FPTC_OP_NOP = 5'h00,
      FPTC_OP_SET_DIR = 5'h01,
      FPTC_OP_SET_PAT = 5'h02,
      FPTC_OP_SET_MASK = 5'h03,
      FPTC_OP_SET_SUPPLY = 5'h04,
      FPTC_OP_SET_RELAY = 5'h05,
      FPTC_OP_SET_LOGIC = 5'h06,
      FPTC_OP_SET_DELAY = 5'h07,
      FPTC_OP_SET_DC_DELAY = 5'h08,
      FPTC_OP_SET_CLOCK = 5'h09,
      FPTC_OP_ROUTE_CLOCK = 5'h0A,
      FPTC_OP_MASK_STROBE = 5'h0B,
      FPTC_OP_ACCUM_MODE = 5'h0C,
      FPTC_OP_COMP_ENABLE = 5'h0D,
      FPTC_OP_FORCE_STROBE = 5'h0E,
      FPTC_OP_CLEAR = 5'h0F,
      FPTC_OP_SET_LIM_HI = 5'h10,
      FPTC_OP_SET_LIM_LO = 5'h11,
      FPTC_OP_FORCE_VAL = 5'h12,
      FPTC_OP_TRIP_ENABLE = 5'h13,
      FPTC_OP_OVERVOLTAGE_DETECT = 5'h14,
      FPTC_OP_TRIP_ACK = 5'h15
   } fptc_op_t;

   // gray along idle -> delay -> strobe, dc wait off idle
   typedef enum logic [1:0] {
      FPTC_ST_IDLE = 2'b00,
      FPTC_ST_DELAY = 2'b01,
      FPTC_ST_STROBE = 2'b11,
      FPTC_ST_DCWAIT = 2'b10
   } fptc_state_t;

endpackage

// File: logic/fptc_top.sv
// functional pin test control: per-pin rank settings, strobe timing, fail capture
`timescale 1ns/100ps
`include "fptc_consts.svh"
// Function
// RULE_01: each of 240 pins independently set as stimulus input or response output
// RULE_02: direction and mask may change between any two functional test steps
// RULE_03: direction write sets each pin of the addressed rank from its bit
// RULE_04: pattern write gives drive state to inputs, expected state to outputs
// RULE_05: mask write marks each pin of the rank care or don't care
// RULE_06: supply-select write picks each pin's input level reference pair
// RULE_07: relay write opens or closes each pin's utility relay
// RULE_08: comparator pass follows selected polarity, positive unless negative chosen
// RULE_09: held strobe delay times the strobe after each new pattern
// RULE_10: held dc delay applied before each dc force operation
// RULE_11: programmable count of sync pulses output during each functional test
// RULE_12: enabled sync pulses routed onto any of the first four pins
// RULE_13: non-latching default clears fail capture before each test's strobe
// RULE_14: latching mode keeps fail capture, accumulating failures over the sequence
// RULE_15: comparators enabled by default strobe into fail capture every test
// RULE_16: comparators disabled load nothing unless masked strobe matches pattern
// RULE_17: masked strobe compares pattern bits 0 to 3 with programmed bits
// RULE_18: enabled supply over its current trip raises a trip event
// RULE_19: enabling a supply's voltage trip switches it into current forcing
// RULE_20: force value outside configured limits rejected with terminal error
// RULE_21: single-strobe command strobes once even with comparators disabled
// RULE_22: clear command returns everything to reset state
// RULE_23: fail bit set only for output, care pin whose level mismatches expectation
// RULE_24: updates synchronous on one clock, pattern applied before delay starts

module fptc_top (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_cmd_valid,
   input wire fptc_pkg::fptc_op_t i_cmd_op,
   input wire logic [`FPTC_RANK_SEL_W-1:0] i_cmd_rank,
   input wire logic [`FPTC_DATA_W-1:0] i_cmd_data,
   input wire logic [`FPTC_NPINS-1:0] i_pin_level,
   input wire logic [`FPTC_NSUP-1:0] i_sup_overcurrent,
   output logic o_ready,
   output logic [`FPTC_NPINS-1:0] o_pin_drive,
   output logic [`FPTC_NPINS-1:0] o_pin_oe,
   output logic [`FPTC_NPINS-1:0] o_supply_sel,
   output logic [`FPTC_NPINS-1:0] o_relay,
   output logic [`FPTC_NPINS-1:0] o_fail,
   output logic [`FPTC_NROUTE-1:0] o_sync,
   output logic o_strobe,
   output logic o_dc_go,
   output logic [`FPTC_DLY_W-1:0] o_force_val,
   output logic o_term_err,
   output logic o_trip_event,
   output logic [`FPTC_NSUP-1:0] o_supply_iforce
);
   import fptc_pkg::*;

   // ****************************************
   // command decode
   // ****************************************
   fptc_state_t state_q, state_d;
   logic go, srst;
   logic [`FPTC_DLY_W-1:0] val;
   logic [`FPTC_RANK_W-1:0] wdat;
   logic [`FPTC_DLY_W-1:0] lim_hi_q, lim_lo_q;
   logic in_lim;

   // commands only taken while idle, so settings never move mid-step
   assign go = i_ce & i_cmd_valid & o_ready; // RULE_24
   assign srst = i_rst | (go & (i_cmd_op == FPTC_OP_CLEAR)); // RULE_22
   assign val = i_cmd_data[`FPTC_DLY_W-1:0];
   assign wdat = i_cmd_data[`FPTC_RANK_W-1:0];
   assign in_lim = (val <= lim_hi_q) & (val >= lim_lo_q);

   // ****************************************
   // per-pin rank settings
   // ****************************************
   logic [`FPTC_NPINS-1:0] dir_q, pat_q, pat_d, mask_q;

   always_comb begin
      pat_d = pat_q;
      if (go && i_cmd_op == FPTC_OP_SET_PAT) begin
         pat_d[i_cmd_rank*`FPTC_RANK_W +: `FPTC_RANK_W] = wdat; // RULE_04
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         dir_q <= '0;
         pat_q <= '0;
         mask_q <= '0;
         o_supply_sel <= '0;
         o_relay <= '0;
      end else if (i_ce) begin
         pat_q <= pat_d;
         if (go) begin
            case (i_cmd_op)
               FPTC_OP_SET_DIR: begin
                  dir_q[i_cmd_rank*`FPTC_RANK_W +: `FPTC_RANK_W] <= wdat; // RULE_03 RULE_02
               end
               FPTC_OP_SET_MASK: begin
                  mask_q[i_cmd_rank*`FPTC_RANK_W +: `FPTC_RANK_W] <= wdat; // RULE_05
               end
               FPTC_OP_SET_SUPPLY: begin
                  o_supply_sel[i_cmd_rank*`FPTC_RANK_W +: `FPTC_RANK_W] <= wdat; // RULE_06
               end
               FPTC_OP_SET_RELAY: begin
                  o_relay[i_cmd_rank*`FPTC_RANK_W +: `FPTC_RANK_W] <= wdat; // RULE_07
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ****************************************
   // test configuration
   // ****************************************
   logic neg_q, comp_en_q, accum_q, mstb_en_q;
   logic [`FPTC_STB_BITS-1:0] mstb_bits_q;
   logic [`FPTC_DLY_W-1:0] dly_q, dcdly_q;
   logic [`FPTC_SYNC_W-1:0] sync_cfg_q;
   logic [`FPTC_NROUTE-1:0] route_q;
   logic [`FPTC_NSUP-1:0] trip_en_q;

   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         neg_q <= 1'b0; // RULE_08
         comp_en_q <= 1'b1; // RULE_15
         accum_q <= 1'b0; // RULE_13
         mstb_en_q <= 1'b0;
         mstb_bits_q <= '0;
         dly_q <= `FPTC_DLY_RST;
         dcdly_q <= `FPTC_DCDLY_RST;
         sync_cfg_q <= `FPTC_SYNC_RST;
         route_q <= '0;
         trip_en_q <= '0;
         o_supply_iforce <= '0;
         lim_hi_q <= `FPTC_LIM_HI_RST;
         lim_lo_q <= `FPTC_LIM_LO_RST;
      end else if (go) begin
         case (i_cmd_op)
            FPTC_OP_SET_LOGIC: neg_q <= i_cmd_data[0]; // RULE_08
            FPTC_OP_SET_DELAY: dly_q <= val; // RULE_09
            FPTC_OP_SET_DC_DELAY: dcdly_q <= val; // RULE_10
            FPTC_OP_SET_CLOCK: sync_cfg_q <= i_cmd_data[`FPTC_SYNC_W-1:0]; // RULE_11
            FPTC_OP_ROUTE_CLOCK: route_q <= i_cmd_data[`FPTC_NROUTE-1:0]; // RULE_12
            FPTC_OP_MASK_STROBE: begin
               mstb_en_q <= i_cmd_data[`FPTC_STB_BITS];
               mstb_bits_q <= i_cmd_data[`FPTC_STB_BITS-1:0]; // RULE_17
            end
            FPTC_OP_ACCUM_MODE: accum_q <= i_cmd_data[0]; // RULE_14
            FPTC_OP_COMP_ENABLE: comp_en_q <= i_cmd_data[0]; // RULE_16
            FPTC_OP_SET_LIM_HI: lim_hi_q <= val;
            FPTC_OP_SET_LIM_LO: lim_lo_q <= val;
            FPTC_OP_TRIP_ENABLE: trip_en_q <= i_cmd_data[`FPTC_NSUP-1:0];
            FPTC_OP_OVERVOLTAGE_DETECT: begin
               // detector on implies the supply now forces current
               o_supply_iforce <= o_supply_iforce | i_cmd_data[`FPTC_NSUP-1:0]; // RULE_19
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   logic [`FPTC_DLY_W-1:0] cnt_q;
   logic [`FPTC_SYNC_W-1:0] sync_left_q;
   logic sync_q;
   logic start_ft, start_dc, delay_done;

   // writing the pattern is what runs a functional test step
   assign start_ft = go & (i_cmd_op == FPTC_OP_SET_PAT);
   assign start_dc = go & (i_cmd_op == FPTC_OP_FORCE_VAL) & in_lim;
   // strobe waits for both the delay and the last sync pulse
   assign delay_done = (cnt_q == '0) & (sync_left_q == '0) & ~sync_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         FPTC_ST_IDLE: begin
            if (start_ft) begin
               state_d = FPTC_ST_DELAY;
            end else if (start_dc) begin
               state_d = FPTC_ST_DCWAIT;
            end
         end
         FPTC_ST_DELAY: begin
            if (delay_done) begin
               state_d = FPTC_ST_STROBE;
            end
         end
         FPTC_ST_STROBE: state_d = FPTC_ST_IDLE;
         FPTC_ST_DCWAIT: begin
            if (cnt_q == '0) begin
               state_d = FPTC_ST_IDLE;
            end
         end
         default: state_d = FPTC_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         state_q <= FPTC_ST_IDLE;
         o_ready <= 1'b1;
      end else if (i_ce) begin
         state_q <= state_d;
         o_ready <= (state_d == FPTC_ST_IDLE);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         if (start_ft) begin
            cnt_q <= dly_q; // RULE_09
         end else if (start_dc) begin
            cnt_q <= dcdly_q; // RULE_10
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // one pulse is one cycle high then one low
   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         sync_left_q <= '0;
         sync_q <= 1'b0;
      end else if (i_ce) begin
         if (start_ft) begin
            sync_left_q <= sync_cfg_q; // RULE_11
            sync_q <= 1'b0;
         end else if (sync_q) begin
            sync_q <= 1'b0;
         end else if (sync_left_q != '0) begin
            sync_q <= 1'b1;
            sync_left_q <= sync_left_q - 1'b1;
         end
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         o_pin_drive <= '0;
         o_pin_oe <= '0;
         o_sync <= '0;
      end else if (i_ce) begin
         // new pattern reaches the pins on the edge the delay starts
         o_pin_drive <= pat_d; // RULE_24
         o_pin_oe <= dir_q; // RULE_01
         o_sync <= {`FPTC_NROUTE{sync_q}};
         for (int k = 0; k < `FPTC_NROUTE; k++) begin
            if (route_q[k]) begin
               o_pin_drive[k] <= sync_q; // RULE_12
               o_pin_oe[k] <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // fail capture
   // ****************************************
   logic [`FPTC_NPINS-1:0] mis;
   logic do_strobe, mstb_hit;

   assign mis = ~dir_q & mask_q & (i_pin_level ^ {`FPTC_NPINS{neg_q}} ^ pat_q); // RULE_23
   assign mstb_hit = mstb_en_q & (pat_q[`FPTC_STB_BITS-1:0] == mstb_bits_q); // RULE_17
   assign do_strobe = ((state_q == FPTC_ST_STROBE) & (comp_en_q | mstb_hit)) // RULE_16
      | (go & (i_cmd_op == FPTC_OP_FORCE_STROBE)); // RULE_21

   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         o_fail <= '0;
         o_strobe <= 1'b0;
      end else if (i_ce) begin
         o_strobe <= do_strobe;
         if (do_strobe) begin
            o_fail <= accum_q ? (o_fail | mis) : mis; // RULE_14
         end else if (start_ft && !accum_q) begin
            o_fail <= '0; // RULE_13
         end
      end
   end

   // ****************************************
   // dc force and supply events
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         o_force_val <= '0;
         o_dc_go <= 1'b0;
         o_term_err <= 1'b0;
      end else if (i_ce) begin
         o_dc_go <= (state_q == FPTC_ST_DCWAIT) & (cnt_q == '0); // RULE_10
         if (start_dc) begin
            o_force_val <= val;
         end
         if (go && i_cmd_op == FPTC_OP_FORCE_VAL && !in_lim) begin
            o_term_err <= 1'b1; // RULE_20
         end
      end
   end

   // set wins over the acknowledge so a trip in that cycle survives
   always_ff @(posedge i_core_clk) begin
      if (srst) begin
         o_trip_event <= 1'b0;
      end else if (i_ce) begin
         if (|(i_sup_overcurrent & trip_en_q)) begin
            o_trip_event <= 1'b1; // RULE_18
         end else if (go && i_cmd_op == FPTC_OP_TRIP_ACK) begin
            o_trip_event <= 1'b0;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   dir_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE_03
      go && i_cmd_op == FPTC_OP_SET_DIR |=> dir_q[0 +: `FPTC_RANK_W] ==
      ($past(i_cmd_rank) == 3'h0 ? $past(wdat) : $past(dir_q[0 +: `FPTC_RANK_W])))
      else $error("direction rank write not stored");
   pat_first_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE_24
      start_ft |=> o_pin_drive[`FPTC_NPINS-1:`FPTC_NROUTE]
      == pat_q[`FPTC_NPINS-1:`FPTC_NROUTE] && state_q == FPTC_ST_DELAY)
      else $error("pattern not on pins when delay starts");
   fail_cause_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_23
      i_ce && !accum_q && do_strobe |=> o_fail == $past(mis))
      else $error("fail capture differs from mismatch");
   fail_accum_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_14
      i_ce && accum_q && !do_strobe |=> (o_fail & $past(o_fail)) == $past(o_fail))
      else $error("accumulated fail bit lost");
   nonlatch_clr_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_13
      i_ce && start_ft && !accum_q |=> o_fail == '0)
      else $error("fail capture not cleared at test start");
   comp_off_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_16
      state_q == FPTC_ST_STROBE && !comp_en_q && !mstb_hit && !go |=> !o_strobe)
      else $error("strobe with comparators disabled");
   strobe_time_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_09
      i_ce && start_ft && sync_cfg_q == '0 && dly_q == 16'h0005 |->
      ##7 state_q == FPTC_ST_STROBE)
      else $error("strobe delay not honoured");
   limit_err_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_20
      go && i_cmd_op == FPTC_OP_FORCE_VAL && !in_lim |=> o_term_err && state_q == FPTC_ST_IDLE)
      else $error("out of limit force not rejected");
   trip_set_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_18
      i_ce && |(i_sup_overcurrent & trip_en_q) |=> o_trip_event)
      else $error("trip not raised");
   iforce_a: assert property (@(posedge i_core_clk) disable iff (srst) // RULE_19
      go && i_cmd_op == FPTC_OP_OVERVOLTAGE_DETECT |=>
      (o_supply_iforce & $past(i_cmd_data[`FPTC_NSUP-1:0])) == $past(i_cmd_data[`FPTC_NSUP-1:0]))
      else $error("supply not in current force");
   clear_all_a: assert property (@(posedge i_core_clk) // RULE_22
      srst |=> o_fail == '0 && o_ready && !o_term_err && o_relay == '0)
      else $error("clear did not reset state");

endmodule

// File: test/fptc_dut_model.sv
// behavioural device-under-test standing on the tester pins
`timescale 1ns/100ps
`include "fptc_consts.svh"
module fptc_dut_model (
   input wire logic [`FPTC_NPINS-1:0] i_pin_oe,
   input wire logic [`FPTC_NPINS-1:0] i_pin_drive,
   input wire logic [`FPTC_NPINS-1:0] i_resp,
   output logic [`FPTC_NPINS-1:0] o_pin_level
);
   // driven pins read back the forced level, the others carry the device response
   assign o_pin_level = (i_pin_oe & i_pin_drive) | (~i_pin_oe & i_resp);
endmodule

// File: test/tb_top.sv
// self-checking bench for the functional pin test control block
`timescale 1ns/100ps
`include "fptc_consts.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
   import fptc_pkg::*;
   typedef struct {
      logic [2:0] rank;
      logic neg;
      logic [29:0] dir, pat, mask, resp, fail;
   } fptc_row_t;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic i_cmd_valid = 1'b0;
   fptc_op_t i_cmd_op = FPTC_OP_NOP;
   logic [2:0] i_cmd_rank = 3'h0;
   logic [29:0] i_cmd_data = 30'h0;
   logic [239:0] resp = 240'h0;
   logic [2:0] overcur = 3'h0;
   logic [239:0] pin_level, o_pin_drive, o_pin_oe, o_supply_sel, o_relay, o_fail;
   logic [3:0] o_sync;
   logic [15:0] o_force_val;
   logic [2:0] o_supply_iforce;
   logic o_ready, o_strobe, o_dc_go, o_term_err, o_trip_event, seen;
   int errors = 0;
   int compares = 0;
   int tick = 0;
   int cyc, sync_rises, pin_rises;
   // pins of a row's rank only; other ranks keep earlier settings
   fptc_row_t rows[5] = '{
      '{3'h0, 1'b0, 30'h0, 30'h0, 30'h3FFFFFFF, 30'h000000FF, 30'h000000FF},
      '{3'h7, 1'b0, 30'h0000FFFF, 30'h0, 30'h3FFFFFFF, 30'h3FFFFFFF, 30'h3FFF0000},
      '{3'h3, 1'b0, 30'h0, 30'h0F0F0F0F, 30'h0000FFFF, 30'h0, 30'h00000F0F},
      '{3'h5, 1'b1, 30'h0, 30'h0, 30'h3FFFFFFF, 30'h0, 30'h3FFFFFFF},
      '{3'h1, 1'b1, 30'h0, 30'h3FFFFFFF, 30'h3FFFFFFF, 30'h0, 30'h0}};

   always #10 i_core_clk = ~i_core_clk;

   fptc_top DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_rank(i_cmd_rank),
      .i_cmd_data(i_cmd_data), .i_pin_level(pin_level), .i_sup_overcurrent(overcur),
      .o_ready(o_ready), .o_pin_drive(o_pin_drive), .o_pin_oe(o_pin_oe),
      .o_supply_sel(o_supply_sel), .o_relay(o_relay), .o_fail(o_fail), .o_sync(o_sync),
      .o_strobe(o_strobe), .o_dc_go(o_dc_go), .o_force_val(o_force_val),
      .o_term_err(o_term_err), .o_trip_event(o_trip_event),
      .o_supply_iforce(o_supply_iforce));

   fptc_dut_model pins (.i_pin_oe(o_pin_oe), .i_pin_drive(o_pin_drive), .i_resp(resp),
      .o_pin_level(pin_level));

   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // held until ready is seen at an edge, at most 100 edges; valid drops at that edge so no op is taken twice
   task automatic cmd(input fptc_op_t op, input logic [2:0] rank, input logic [29:0] data);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_cmd_valid <= 1'b1;
      i_cmd_op <= op;
      i_cmd_rank <= rank;
      i_cmd_data <= data;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_ready !== 1'b1 && n < 100);
      if (o_ready !== 1'b1) errors++;
      i_cmd_valid <= 1'b0;
   endtask

   task automatic wait_for(input logic dc);
      logic p, q;
      seen = 1'b0;
      cyc = 0;
      sync_rises = 0;
      pin_rises = 0;
      p = 1'b0;
      q = 1'b0;
      while (!seen && cyc < 60) begin
         @(posedge i_core_clk);
         #1;
         cyc++;
         if (o_sync[0] === 1'b1 && !p) sync_rises++;
         if (o_pin_drive[0] === 1'b1 && !q) pin_rises++;
         p = (o_sync[0] === 1'b1);
         q = (o_pin_drive[0] === 1'b1);
         seen = dc ? (o_dc_go === 1'b1) : (o_strobe === 1'b1);
      end
   endtask

   task automatic run_pat(input logic [2:0] rank, input logic [29:0] data);
      cmd(FPTC_OP_SET_PAT, rank, data);
      wait_for(1'b0);
   endtask

   task automatic settle;
      @(posedge i_core_clk);
      #1;
   endtask

   always @(posedge i_core_clk) begin
      tick++;
      if (tick == 10000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      int b, c1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      #1;
      `CHK(o_ready, 1'b1)
      `CHK(o_fail, 240'h0)
      `CHK(o_pin_oe, 240'h0)
      // ordinary functional tests, one rank each
      foreach (rows[i]) begin
         b = rows[i].rank * 30;
         resp[b +: 30] <= rows[i].resp;
         cmd(FPTC_OP_SET_LOGIC, 3'h0, {29'h0, rows[i].neg});
         cmd(FPTC_OP_SET_DIR, rows[i].rank, rows[i].dir);
         cmd(FPTC_OP_SET_MASK, rows[i].rank, rows[i].mask);
         run_pat(rows[i].rank, rows[i].pat);
         `CHK(cyc, 3)
         `CHK(o_fail[b +: 30], rows[i].fail)
         `CHK(o_pin_oe[b +: 30], rows[i].dir)
         `CHK(o_pin_drive[b +: 30], rows[i].pat)
      end
      // accumulate across tests, then back to clearing
      cmd(FPTC_OP_SET_LOGIC, 3'h0, 30'h0);
      resp[29:0] <= 30'h1;
      run_pat(3'h0, 30'h0);
      `CHK(o_fail[29:0], 30'h1)
      cmd(FPTC_OP_ACCUM_MODE, 3'h0, 30'h1);
      resp[29:0] <= 30'h2;
      run_pat(3'h0, 30'h0);
      `CHK(o_fail[29:0], 30'h3)
      cmd(FPTC_OP_ACCUM_MODE, 3'h0, 30'h0);
      run_pat(3'h0, 30'h0);
      `CHK(o_fail[29:0], 30'h2)
      // comparators off: only a matching masked strobe or a forced strobe loads
      resp[29:0] <= 30'h4;
      cmd(FPTC_OP_COMP_ENABLE, 3'h0, 30'h0);
      run_pat(3'h0, 30'h0);
      `CHK(seen, 1'b0)
      `CHK(o_fail[29:0], 30'h0)
      cmd(FPTC_OP_MASK_STROBE, 3'h0, 30'h15);
      run_pat(3'h0, 30'h5);
      `CHK(seen, 1'b1)
      `CHK(o_fail[29:0], 30'h1)
      run_pat(3'h0, 30'h6);
      `CHK(seen, 1'b0)
      cmd(FPTC_OP_FORCE_STROBE, 3'h0, 30'h0);
      #1;
      `CHK(o_strobe, 1'b1)
      `CHK(o_fail[29:0], 30'h2)
      cmd(FPTC_OP_COMP_ENABLE, 3'h0, 30'h1);
      cmd(FPTC_OP_MASK_STROBE, 3'h0, 30'h0);
      // strobe delay and sync pulses
      cmd(FPTC_OP_SET_DELAY, 3'h0, 30'h5);
      run_pat(3'h0, 30'h0);
      `CHK(cyc, 7)
      `CHK(seen, 1'b1)
      cmd(FPTC_OP_SET_DELAY, 3'h0, 30'h1);
      cmd(FPTC_OP_SET_CLOCK, 3'h0, 30'h3);
      cmd(FPTC_OP_ROUTE_CLOCK, 3'h0, 30'h1);
      run_pat(3'h0, 30'h0);
      `CHK(sync_rises, 3)
      `CHK(pin_rises, 3)
      `CHK(o_pin_oe[0], 1'b1)
      cmd(FPTC_OP_SET_CLOCK, 3'h0, 30'h0);
      cmd(FPTC_OP_ROUTE_CLOCK, 3'h0, 30'h0);
      // force values: inclusive limits, dc delay, rejection
      cmd(FPTC_OP_SET_LIM_LO, 3'h0, 30'hA);
      cmd(FPTC_OP_SET_LIM_HI, 3'h0, 30'h14);
      cmd(FPTC_OP_FORCE_VAL, 3'h0, 30'h14);
      wait_for(1'b1);
      `CHK(o_force_val, 16'h0014)
      c1 = cyc;
      cmd(FPTC_OP_SET_DC_DELAY, 3'h0, 30'h3);
      cmd(FPTC_OP_FORCE_VAL, 3'h0, 30'hA);
      wait_for(1'b1);
      `CHK(cyc - c1, 2)
      cmd(FPTC_OP_FORCE_VAL, 3'h0, 30'h15);
      wait_for(1'b1);
      `CHK(seen, 1'b0)
      `CHK(o_term_err, 1'b1)
      `CHK(o_force_val, 16'h000A)
      // trips on enabled supplies only
      cmd(FPTC_OP_TRIP_ENABLE, 3'h0, 30'h2);
      overcur <= 3'h1;
      repeat (3) settle();
      `CHK(o_trip_event, 1'b0)
      @(posedge i_core_clk);
      overcur <= 3'h2;
      repeat (3) settle();
      `CHK(o_trip_event, 1'b1)
      @(posedge i_core_clk);
      overcur <= 3'h0;
      cmd(FPTC_OP_TRIP_ACK, 3'h0, 30'h0);
      settle();
      `CHK(o_trip_event, 1'b0)
      cmd(FPTC_OP_OVERVOLTAGE_DETECT, 3'h0, 30'h4);
      cmd(FPTC_OP_SET_SUPPLY, 3'h2, 30'h2AAAAAAA);
      cmd(FPTC_OP_SET_RELAY, 3'h2, 30'h15555555);
      settle();
      `CHK(o_supply_iforce, 3'h4)
      `CHK(o_supply_sel[60 +: 30], 30'h2AAAAAAA)
      `CHK(o_relay[60 +: 30], 30'h15555555)
      cmd(FPTC_OP_CLEAR, 3'h0, 30'h0);
      settle();
      `CHK(o_relay, 240'h0)
      `CHK(o_pin_oe, 240'h0)
      `CHK(o_term_err, 1'b0)
      `CHK(o_supply_iforce, 3'h0)
      // clock enable low: a command is not taken
      @(posedge i_core_clk);
      i_ce <= 1'b0;
      cmd(FPTC_OP_SET_RELAY, 3'h0, 30'h1);
      i_ce <= 1'b1;
      settle();
      `CHK(o_relay[29:0], 30'h0)
      // reset in mid-test: step abandoned, no strobe follows
      cmd(FPTC_OP_SET_PAT, 3'h0, 30'h3);
      i_rst <= 1'b1;
      @(posedge i_core_clk);
      i_rst <= 1'b0;
      settle();
      `CHK(o_ready, 1'b1)
      `CHK(o_pin_drive, 240'h0)
      wait_for(1'b0);
      `CHK(seen, 1'b0)
      tally_and_finish();
   end
endmodule
